// [rtl/metering_peak_status_regs.sv]
// Voltage peak and first event status registers behind an AXI4-Lite slave

module metering_peak_status_regs (
  // Clock and reset
  input  wire  logic                               aclk,
  input  wire  logic                               aresetn,
  // AXI4-Lite write address
  input  wire  logic [metering_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire  logic [2:0]                         s_axi_awprot,
  input  wire  logic                               s_axi_awvalid,
  output logic                                     s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [metering_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire  logic [3:0]                         s_axi_wstrb,
  input  wire  logic                               s_axi_wvalid,
  output logic                                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire  logic                               s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [metering_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire  logic [2:0]                         s_axi_arprot,
  input  wire  logic                               s_axi_arvalid,
  output logic                                     s_axi_arready,
  // AXI4-Lite read data
  output logic [metering_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire  logic                               s_axi_rready,
  // Voltage peak samples
  input  wire  logic                               peak_sample_valid,
  input  wire  logic [metering_pkg::PEAK_VAL_W-1:0] peak_sample_mag,
  input  wire  logic [2:0]                         peak_sample_phase,
  input  wire  logic                               peak_restart,
  // Energy and power datapath
  input  wire  metering_pkg::energy_bit30_s        energy_bit30,
  input  wire  metering_pkg::power_sign_s          power_signs,
  input  wire  logic                               line_cycle_done,
  input  wire  logic                               compute_cycle_done,
  // Pulse generators, active low
  input  wire  logic [2:0]                         pulse_gen_n,
  // Pulse pins and datapath control
  output logic [2:0]                               pulse_out_n,
  output logic [2:0][metering_pkg::PULSE_SEL_W-1:0] pulse_source,
  output logic                                     active_sign_source_select,
  output logic                                     reactive_sign_source_select
);

  // ==========================================================================
  // Declarations
  logic [metering_pkg::PEAK_VAL_W-1:0]   peak_voltage_value_q;
  logic [2:0]                            peak_source_phase_flags_q;
  logic [metering_pkg::STATUS_W-1:0]     status_q;
  logic [metering_pkg::STATUS_W-1:0]     status_d;
  logic [metering_pkg::STATUS_W-1:0]     status_set;
  logic [metering_pkg::STATUS_W-1:0]     status_clr;
  logic [1:0]                            measurement_mode_reg_q;
  logic [metering_pkg::PULSE_MODE_W-1:0] pulse_mode_reg_q;
  logic [metering_pkg::SIGN_W-1:0]       power_sign_reg_q;
  logic [metering_pkg::SIGN_W-1:0]       sign_now;
  metering_pkg::energy_bit30_s           bit30_prev_q;
  metering_pkg::energy_bit30_s           bit30_chg;
  logic [2:0]                            pulse_prev_n_q;
  logic                                  sign_primed_q;

  logic                                  aw_held_q;
  logic                                  w_held_q;
  logic [15:0]                           aw_idx_q;
  logic [metering_pkg::DATA_W-1:0]       wdata_q;
  logic [3:0]                            wstrb_q;
  logic                                  wr_fire;
  logic [31:0]                           wmask;
  logic [15:0]                           ar_idx;
  logic [metering_pkg::DATA_W-1:0]       rd_word;
  logic                                  rd_hit;

  // ==========================================================================
  // Write channel capture; address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[metering_pkg::ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Ready is registered, so it drops the cycle after a beat is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_q[b]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= metering_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_idx_q)
        metering_pkg::VOLTAGE_PEAK_IDX, metering_pkg::EVENT_STATUS_FIRST_IDX,
        metering_pkg::MEASUREMENT_MODE_IDX, metering_pkg::PULSE_MODE_IDX,
        metering_pkg::POWER_SIGN_IDX: s_axi_bresp <= metering_pkg::RESP_OKAY;
        default: s_axi_bresp <= metering_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Writable control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measurement_mode_reg_q <= metering_pkg::MODE_RST;
    end else if (wr_fire && aw_idx_q == metering_pkg::MEASUREMENT_MODE_IDX) begin
      measurement_mode_reg_q <= (measurement_mode_reg_q & ~wmask[1:0])
                              | (wdata_q[1:0] & wmask[1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_mode_reg_q <= metering_pkg::PULSE_MODE_RST;
    end else if (wr_fire && aw_idx_q == metering_pkg::PULSE_MODE_IDX) begin
      pulse_mode_reg_q <= (pulse_mode_reg_q & ~wmask[metering_pkg::PULSE_MODE_W-1:0])
                        | (wdata_q[metering_pkg::PULSE_MODE_W-1:0]
                           & wmask[metering_pkg::PULSE_MODE_W-1:0]);
    end
  end

  // ==========================================================================
  // Voltage peak tracking
  // largest magnitude, source phases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_voltage_value_q      <= 24'h00_0000;
      peak_source_phase_flags_q <= 3'h0;
    end else if (peak_restart) begin
      peak_voltage_value_q      <= 24'h00_0000;
      peak_source_phase_flags_q <= 3'h0;
    end else if (peak_sample_valid) begin
      if (peak_sample_mag > peak_voltage_value_q) begin
        peak_voltage_value_q      <= peak_sample_mag;
        peak_source_phase_flags_q <= peak_sample_phase;
      end else if (peak_sample_mag == peak_voltage_value_q && peak_sample_mag != 24'h00_0000) begin
        // Nonzero ties mark every phase that reached the peak; a zero sample marks none
        peak_source_phase_flags_q <= peak_source_phase_flags_q | peak_sample_phase;
      end
    end
  end

  // ==========================================================================
  // Power signs; active and reactive selected by the mode register, sums passed straight
  // total or fundamental source
  always_comb begin
    sign_now = '0;
    sign_now[metering_pkg::SIGN_ACTIVE_LSB +: 3] =
      measurement_mode_reg_q[metering_pkg::MODE_ACTIVE_SEL]
        ? power_signs.fund_active : power_signs.total_active;
    sign_now[metering_pkg::SIGN_REACTIVE_LSB +: 3] =
      measurement_mode_reg_q[metering_pkg::MODE_REACTIVE_SEL]
        ? power_signs.fund_reactive : power_signs.total_reactive;
    sign_now[metering_pkg::SIGN_SUM_ONE]   = power_signs.sum[0];
    sign_now[metering_pkg::SIGN_SUM_TWO]   = power_signs.sum[1];
    sign_now[metering_pkg::SIGN_SUM_THREE] = power_signs.sum[2];
  end

  // First cycle after reset only loads the signs, so no false flip is flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_sign_reg_q <= '0;
      sign_primed_q    <= 1'b0;
    end else begin
      power_sign_reg_q <= sign_now;
      sign_primed_q    <= 1'b1;
    end
  end

  // ==========================================================================
  // Event history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit30_prev_q   <= '0;
      pulse_prev_n_q <= 3'h7;
    end else begin
      bit30_prev_q   <= energy_bit30;
      pulse_prev_n_q <= pulse_gen_n;
    end
  end

  // History holds its reset value on the first cycle, so no change is flagged then
  assign bit30_chg = sign_primed_q
                   ? energy_bit30 ^ bit30_prev_q
                   : '0;

  always_comb begin
    status_set = '0;
    status_set[metering_pkg::ST_TOTAL_ACTIVE_HF]   = |bit30_chg.total_active;
    status_set[metering_pkg::ST_FUND_ACTIVE_HF]    = |bit30_chg.fund_active;
    status_set[metering_pkg::ST_TOTAL_REACTIVE_HF] = |bit30_chg.total_reactive;
    status_set[metering_pkg::ST_FUND_REACTIVE_HF]  = |bit30_chg.fund_reactive;
    status_set[metering_pkg::ST_APPARENT_HF]       = |bit30_chg.apparent;
    status_set[metering_pkg::ST_LINE_CYCLE_DONE]   = line_cycle_done;
    status_set[metering_pkg::ST_ACTIVE_FLIP_LSB +: 3] = {3{sign_primed_q}}
      & (sign_now[metering_pkg::SIGN_ACTIVE_LSB +: 3]
         ^ power_sign_reg_q[metering_pkg::SIGN_ACTIVE_LSB +: 3]);
    status_set[metering_pkg::ST_SUM_ONE_FLIP] = sign_primed_q
      & (sign_now[metering_pkg::SIGN_SUM_ONE] ^ power_sign_reg_q[metering_pkg::SIGN_SUM_ONE]);
    status_set[metering_pkg::ST_REACTIVE_FLIP_LSB +: 3] = {3{sign_primed_q}}
      & (sign_now[metering_pkg::SIGN_REACTIVE_LSB +: 3]
         ^ power_sign_reg_q[metering_pkg::SIGN_REACTIVE_LSB +: 3]);
    status_set[metering_pkg::ST_SUM_TWO_FLIP] = sign_primed_q
      & (sign_now[metering_pkg::SIGN_SUM_TWO] ^ power_sign_reg_q[metering_pkg::SIGN_SUM_TWO]);
    // falling pulse edge, regardless of disable
    status_set[metering_pkg::ST_PULSE_LSB +: 3] = pulse_prev_n_q & ~pulse_gen_n;
    status_set[metering_pkg::ST_COMPUTE_DONE] = compute_cycle_done;
    status_set[metering_pkg::ST_SUM_THREE_FLIP] = sign_primed_q
      & (sign_now[metering_pkg::SIGN_SUM_THREE]
         ^ power_sign_reg_q[metering_pkg::SIGN_SUM_THREE]);
  end

  // ==========================================================================
  // Event status, write one to clear
  always_comb begin
    status_clr = '0;
    if (wr_fire && aw_idx_q == metering_pkg::EVENT_STATUS_FIRST_IDX) begin
      status_clr = wdata_q[metering_pkg::STATUS_W-1:0] & wmask[metering_pkg::STATUS_W-1:0];
    end
  end

  // set wins over a same-cycle clear
  assign status_d = (status_q & ~status_clr) | status_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // ==========================================================================
  // Pulse pins and datapath selects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out_n <= 3'h7;
    end else begin
      // Disabled outputs idle high
      pulse_out_n <= pulse_gen_n | pulse_mode_reg_q[metering_pkg::PULSE_DIS_LSB +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_source <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pulse_source[i] <= pulse_mode_reg_q[metering_pkg::PULSE_SEL_LSB
                                            + i*metering_pkg::PULSE_SEL_W +: 3];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_sign_source_select   <= 1'b0;
      reactive_sign_source_select <= 1'b0;
    end else begin
      active_sign_source_select   <= measurement_mode_reg_q[metering_pkg::MODE_ACTIVE_SEL];
      reactive_sign_source_select <= measurement_mode_reg_q[metering_pkg::MODE_REACTIVE_SEL];
    end
  end

  // ==========================================================================
  // Read channel
  assign ar_idx = s_axi_araddr[metering_pkg::ADDR_W-1:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (ar_idx)
      metering_pkg::VOLTAGE_PEAK_IDX: begin
        rd_word[metering_pkg::PEAK_VAL_W-1:0]         = peak_voltage_value_q;
        rd_word[metering_pkg::PEAK_PHASE_LSB +: 3]    = peak_source_phase_flags_q;
      end
      metering_pkg::EVENT_STATUS_FIRST_IDX: begin
        rd_word[metering_pkg::STATUS_W-1:0] = status_q;
      end
      metering_pkg::MEASUREMENT_MODE_IDX: begin
        rd_word[1:0] = measurement_mode_reg_q;
      end
      metering_pkg::PULSE_MODE_IDX: begin
        rd_word[metering_pkg::PULSE_MODE_W-1:0] = pulse_mode_reg_q;
      end
      metering_pkg::POWER_SIGN_IDX: begin
        rd_word[metering_pkg::SIGN_W-1:0] = power_sign_reg_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= metering_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? metering_pkg::RESP_OKAY : metering_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [rtl/metering_pkg.sv]
// Shared constants and carrier types for the peak and event status registers
package metering_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [15:0] VOLTAGE_PEAK_IDX       = 16'hE501;
  localparam logic [15:0] EVENT_STATUS_FIRST_IDX = 16'hE502;
  localparam logic [15:0] MEASUREMENT_MODE_IDX   = 16'hE600;
  localparam logic [15:0] PULSE_MODE_IDX         = 16'hE601;
  localparam logic [15:0] POWER_SIGN_IDX         = 16'hE602;

  // ==========================================================================
  // Voltage peak layout
  localparam int PEAK_VAL_W     = 24;
  localparam int PEAK_PHASE_LSB = 24;

  // ==========================================================================
  // Event status bit positions
  localparam int ST_TOTAL_ACTIVE_HF   = 0;
  localparam int ST_FUND_ACTIVE_HF    = 1;
  localparam int ST_TOTAL_REACTIVE_HF = 2;
  localparam int ST_FUND_REACTIVE_HF  = 3;
  localparam int ST_APPARENT_HF       = 4;
  localparam int ST_LINE_CYCLE_DONE   = 5;
  localparam int ST_ACTIVE_FLIP_LSB   = 6;
  localparam int ST_SUM_ONE_FLIP      = 9;
  localparam int ST_REACTIVE_FLIP_LSB = 10;
  localparam int ST_SUM_TWO_FLIP      = 13;
  localparam int ST_PULSE_LSB         = 14;
  localparam int ST_COMPUTE_DONE      = 17;
  localparam int ST_SUM_THREE_FLIP    = 18;
  localparam int STATUS_W             = 19;

  // ==========================================================================
  // Mode, pulse mode and sign register layout
  localparam int MODE_ACTIVE_SEL   = 0;
  localparam int MODE_REACTIVE_SEL = 1;
  localparam int PULSE_SEL_W       = 3;
  localparam int PULSE_SEL_LSB     = 0;
  localparam int PULSE_DIS_LSB     = 9;
  localparam int PULSE_MODE_W      = 12;
  localparam int SIGN_ACTIVE_LSB   = 0;
  localparam int SIGN_SUM_ONE      = 3;
  localparam int SIGN_REACTIVE_LSB = 4;
  localparam int SIGN_SUM_TWO      = 7;
  localparam int SIGN_SUM_THREE    = 8;
  localparam int SIGN_W            = 9;

  // ==========================================================================
  // Reset values
  localparam logic [1:0]              MODE_RST       = 2'h0;
  localparam logic [PULSE_MODE_W-1:0] PULSE_MODE_RST = 12'h000;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] total_active;
    logic [2:0] fund_active;
    logic [2:0] total_reactive;
    logic [2:0] fund_reactive;
    logic [2:0] apparent;
  } energy_bit30_s;

  typedef struct packed {
    logic [2:0] total_active;
    logic [2:0] fund_active;
    logic [2:0] total_reactive;
    logic [2:0] fund_reactive;
    logic [2:0] sum;
  } power_sign_s;

endpackage

// [verif/metering_peak_status_properties.sv]
// Bus, peak read and pulse pin properties of the peak and status register block
module metering_peak_status_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pulse pins
  input wire logic [2:0]  pulse_gen_n,
  input wire logic [2:0]  pulse_out_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Read target, so read data can be tied to its register
  logic [15:0] rd_idx_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_idx_q <= 16'h0000;
    else if (s_axi_arvalid && s_axi_arready) rd_idx_q <= s_axi_araddr[17:2];
  end
  // ==========================================================================
  // Properties
  property p_peak_top;
    s_axi_rvalid && rd_idx_q == metering_pkg::VOLTAGE_PEAK_IDX |->
      s_axi_rdata[31:27] == 5'h00 && s_axi_rresp == metering_pkg::RESP_OKAY;
  endproperty
  a_peak_top: assert property (p_peak_top) else $error("peak upper bits not zero");
  property p_status_top;
    s_axi_rvalid && rd_idx_q == metering_pkg::EVENT_STATUS_FIRST_IDX |->
      s_axi_rdata[31:19] == 13'h0000;
  endproperty
  a_status_top: assert property (p_status_top) else $error("status upper bits set");
  property p_pulse_pin;
    (~pulse_out_n & $past(pulse_gen_n)) == 3'h0;
  endproperty
  a_pulse_pin: assert property (p_pulse_pin) else $error("pulse pin low without cause");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late or reaccepted");
  property p_aw_busy;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write taken during response");
  property p_b_clear;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2];
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("write response repeated");
endmodule

bind metering_peak_status_regs metering_peak_status_properties chk_u (.*);

// [verif/tb_metering_peak_status_regs.sv]
// Self-checking bench for the peak and event status register block
module tb_metering_peak_status_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] PK = metering_pkg::VOLTAGE_PEAK_IDX;
  localparam logic [15:0] ST = metering_pkg::EVENT_STATUS_FIRST_IDX;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, peak_sample_valid, peak_restart, line_cycle_done;
  logic        compute_cycle_done, active_sign_source_select, reactive_sign_source_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  s_axi_awprot, s_axi_arprot, peak_sample_phase, pulse_gen_n, pulse_out_n, p;
  logic [3:0]  s_axi_wstrb;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
  logic [23:0] peak_sample_mag, m;
  logic [26:0] pk;
  logic [2:0][2:0] pulse_source;
  metering_pkg::energy_bit30_s energy_bit30;
  metering_pkg::power_sign_s   power_signs;
  int          mismatches, num_checks;

  metering_peak_status_regs dut_u (.*);
  always #5 aclk = ~aclk;

  function automatic logic [26:0] peak_upd(logic [26:0] c, logic [23:0] v, logic [2:0] ph);
    if (v > c[23:0]) return {ph, v};
    if (v == c[23:0] && v != 24'h0) return {c[26:24] | ph, v};
    return c;
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; waits on the handshakes, the watchdog bounds a hang
  task automatic bus(input bit wr, input logic [15:0] idx, input logic [31:0] wd);
    bit aw_ok, w_ok, ar_ok;
    aw_ok = !wr;
    w_ok = !wr;
    ar_ok = wr;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_araddr <= {idx, 2'h0};
    s_axi_wdata <= wd;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    while (!(aw_ok && w_ok && ar_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw_ok = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
      if (s_axi_arvalid && s_axi_arready) ar_ok = 1'b1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
    do @(posedge aclk); while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  // Flag must show alone, survive a write of ones to the other bits, then clear on a one write
  task automatic ev(input int b);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h1 << b);
    bus(1'b1, ST, ~(32'h1 << b));
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h1 << b);
    bus(1'b1, ST, 32'h1 << b);
    chk(rsp, metering_pkg::RESP_OKAY);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {peak_sample_valid, peak_restart, line_cycle_done, compute_cycle_done} = 4'h0;
    {peak_sample_mag, peak_sample_phase, energy_bit30, power_signs} = '0;
    s_axi_wstrb = 4'hF;
    pulse_gen_n = 3'h7;
    aresetn = 1'b0;
    void'($urandom(76));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, PK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 16'h0000, 32'h0);
    chk({rsp, rd}, {metering_pkg::RESP_SLVERR, 32'h0});
    bus(1'b1, 16'h0000, 32'h0);
    chk(rsp, metering_pkg::RESP_SLVERR);
    bus(1'b1, PK, 32'hFFFFFFFF);
    bus(1'b0, PK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, metering_pkg::MEASUREMENT_MODE_IDX, 32'h3);
    #1 chk({active_sign_source_select, reactive_sign_source_select}, 2'h3);
    d = {23'h000007, 3'($urandom), 3'($urandom), 3'($urandom)};
    bus(1'b1, metering_pkg::PULSE_MODE_IDX, d);
    #1 chk(pulse_source, d[8:0]);
    pk = 27'h0;
    for (int i = 0; i < 24; i++) begin
      m = (i == 22) ? 24'hFFFFFF : (i == 23) ? pk[23:0] : 24'($urandom);
      p = 3'h1 << $urandom_range(2);
      @(posedge aclk);
      peak_sample_valid <= 1'b1;
      peak_sample_mag <= m;
      peak_sample_phase <= p;
      pk = peak_upd(pk, m, p);
    end
    @(posedge aclk);
    peak_sample_valid <= 1'b0;
    bus(1'b0, PK, 32'h0);
    chk(rd, {5'h00, pk});
    @(posedge aclk);
    peak_restart <= 1'b1;
    @(posedge aclk);
    peak_restart <= 1'b0;
    bus(1'b0, PK, 32'h0);
    chk(rd, 32'h0);
    for (int e = 0; e < 15; e++) begin
      @(posedge aclk);
      energy_bit30 <= energy_bit30 ^ 15'(1 << e);
      ev(4 - e / 3);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      power_signs <= power_signs ^ 15'(15'h1200 << i);
      ev(6 + i);
      @(posedge aclk);
      power_signs <= power_signs ^ 15'(15'h0048 << i);
      ev(10 + i);
      @(posedge aclk);
      power_signs <= power_signs ^ 15'(1 << i);
      ev(i == 0 ? 9 : i == 1 ? 13 : 18);
      @(posedge aclk);
      pulse_gen_n <= ~(3'h1 << i);
      @(posedge aclk);
      pulse_gen_n <= 3'h7;
      #1 chk(pulse_out_n, 3'h7);
      ev(14 + i);
    end
    // Unselected total sources must not flag while fundamental is selected
    @(posedge aclk);
    power_signs <= power_signs ^ 15'h71C0;
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, metering_pkg::POWER_SIGN_IDX, 32'h0);
    chk(rd, 32'h1FF);
    @(posedge aclk);
    line_cycle_done <= 1'b1;
    @(posedge aclk);
    line_cycle_done <= 1'b0;
    ev(5);
    compute_cycle_done <= 1'b1;
    @(posedge aclk);
    compute_cycle_done <= 1'b0;
    ev(17);
    bus(1'b1, metering_pkg::PULSE_MODE_IDX, {23'h0, d[8:0]});
    pulse_gen_n <= 3'h6;
    @(posedge aclk);
    pulse_gen_n <= 3'h7;
    #1 chk(pulse_out_n, 3'h6);
    ev(14);
    conclude();
  end
endmodule
